/* File: core/tid_pkg.sv */
// Constants, types and tester register map for the TAP identification path.
// Assumes both ends and the bench import it.
package tid_pkg;
  localparam int unsigned TID_IR_W = 6;
  localparam int unsigned TID_ID_W = 32;
  localparam logic [5:0] TID_IR_IDCODE = 6'h02;
  localparam logic [5:0] TID_IR_BYPASS = 6'h3f;
  localparam logic [5:0] TID_IR_CAPTURE = 6'h2d;
  localparam logic [5:0] TID_RSV1_LO = 6'h04;
  localparam logic [5:0] TID_RSV1_HI = 6'h2c;
  localparam logic [5:0] TID_RSV2_LO = 6'h2e;
  localparam logic [5:0] TID_RSV2_HI = 6'h3c;
  localparam int unsigned TID_MAKER_LSB = 1;
  localparam int unsigned TID_MAKER_W = 11;
  localparam int unsigned TID_PART_LSB = 12;
  localparam int unsigned TID_PART_W = 16;
  localparam int unsigned TID_VER_LSB = 28;
  localparam int unsigned TID_VER_W = 4;
  localparam int unsigned TID_PIN_TCK = 0;
  localparam int unsigned TID_PIN_TMS = 1;
  localparam int unsigned TID_PIN_TDI = 2;
  localparam int unsigned TID_PIN_TRST = 3;
  localparam int unsigned TID_TCK_HALF_CYC = 12;
  // Tester register byte offsets and fields
  localparam logic [7:0] TID_REG_CMD = 8'h00;
  localparam logic [7:0] TID_REG_DATA = 8'h04;
  localparam logic [7:0] TID_REG_RESULT = 8'h08;
  localparam logic [7:0] TID_REG_STATUS = 8'h0c;
  localparam logic [7:0] TID_REG_PARK = 8'h10;
  localparam int unsigned TID_CMD_IR_LSB = 8;
  localparam int unsigned TID_ST_BUSY = 0;
  localparam int unsigned TID_ST_IDP = 1;
  localparam int unsigned TID_ST_REFUSED = 2;
  localparam logic TID_PARK_RST = 1'b1;
  localparam logic [31:0] TID_DATA_RST = 32'h0;
  // Canned TMS walks, one bit per test clock, bit 0 first
  localparam logic [63:0] TID_TMS_RESET = 64'h0000_0000_0000_001f;
  localparam logic [63:0] TID_TMS_IR = 64'h0000_0000_0000_0603;
  localparam logic [63:0] TID_TMS_DR = 64'h0000_000c_0000_0001;
  localparam logic [63:0] TID_TMS_ID = 64'h0000_0300_0000_005f;
  localparam logic [6:0] TID_LEN_RESET = 7'h06;
  localparam logic [6:0] TID_LEN_IR = 7'h0c;
  localparam logic [6:0] TID_LEN_DR = 7'h25;
  localparam logic [6:0] TID_LEN_ID = 7'h2b;
  localparam logic [6:0] TID_CAP_NONE = 7'h40;
  localparam logic [6:0] TID_CAP_IR = 7'h04;
  localparam logic [6:0] TID_CAP_DR = 7'h03;
  localparam logic [6:0] TID_CAP_ID = 7'h09;
  localparam logic [6:0] TID_CAP_SPAN = 7'h20;
  typedef enum logic [3:0] {
    TID_TLR, TID_RTI, TID_SEL_DR, TID_CAP_DR_S, TID_SH_DR, TID_EX1_DR, TID_PAU_DR,
    TID_EX2_DR, TID_UPD_DR, TID_SEL_IR, TID_CAP_IR_S, TID_SH_IR, TID_EX1_IR,
    TID_PAU_IR, TID_EX2_IR, TID_UPD_IR
  } tid_tap_t;
  typedef enum logic [1:0] {
    TID_OP_RESET, TID_OP_READ_ID, TID_OP_SCAN_IR, TID_OP_SCAN_DR
  } tid_op_t;
  typedef enum logic [1:0] {TID_ENG_IDLE, TID_ENG_LOW, TID_ENG_HIGH} tid_eng_t;
endpackage

/* File: core/tid_if.sv */
// Test port wires between the tester and the device.
// Assumes TDO is pulled up on the board when the device does not drive it.
`timescale 1ns/1ps
interface tid_if;
  logic tck;
  logic tms;
  logic tdi;
  logic trst_n;
  logic tdo;
  logic tdo_oe;
  logic tdo_line;
  assign tdo_line = tdo_oe ? tdo : 1'b1;
  modport dev (input tck, input tms, input tdi, input trst_n, output tdo, output tdo_oe);
  modport tst (output tck, output tms, output tdi, output trst_n, input tdo_line);
endinterface

/* File: core/tid_sync.sv */
// Two-stage synchroniser for a vector of independent pin levels.
// Assumes each bit is a slow level; no bus coherence is kept across bits.
`timescale 1ns/1ps
module tid_sync #(
  parameter int unsigned W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tid_sync_st_t;
  tid_sync_st_t r_q, r_d;
  always_comb begin
    r_d = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
  assign q = r_q.s2;
endmodule

/* File: core/tid_device.sv */
// Device end of the test port: TAP controller, instruction register,
// identification register and bypass register.
// Assumes the test pins come from another clock domain and are far slower than aclk.
//
// Contract
// - TAP reset makes IDCODE the current instruction
// - Identification bit 0 is 1, shifted first
// - Tester reads first bit: 1 id, 0 bypass
// - Bypass register exists, never default after reset
// - IDCODE plus Shift-DR shifts 32 identification bits
// - Layout: bit0 high, maker, part, version fields
// - Version field shows the silicon revision input
// - Capture-IR loads fixed pattern ending binary 01
// - Tester never selects reserved instruction codes
// - Tester holds TAP in reset when unused
// - Tester drives idle test clock steady low
// - Six-bit IR shifts on rise, applies at Update-IR
// - IDCODE 000010, BYPASS 111111, capture pattern 101101
// - Bypass captures 0, one-bit path TDI to TDO
`timescale 1ns/1ps
module tid_device #(
  parameter logic [10:0] MAKER = 11'h555,  // Arbitrary value
  parameter logic [15:0] PART = 16'h1234   // Arbitrary value
) (
  input wire logic aclk,
  input wire logic aresetn,
  tid_if.dev tap,
  input wire logic [tid_pkg::TID_VER_W-1:0] version,
  output logic [tid_pkg::TID_IR_W-1:0] cur_instr,
  output tid_pkg::tid_tap_t tap_state
);
  import tid_pkg::*;

  typedef struct packed {
    tid_tap_t st;
    logic tck_prev;
    logic [TID_IR_W-1:0] ir_sh;
    logic [TID_IR_W-1:0] ir;
    logic [TID_ID_W-1:0] id_sh;
    logic byp;
    logic tdo;
    logic tdo_oe;
  } tid_dev_st_t;

  localparam tid_dev_st_t TID_DEV_RST = '{
    st: TID_TLR,
    tck_prev: 1'b0,
    ir_sh: '0,
    ir: TID_IR_IDCODE,
    id_sh: '0,
    byp: 1'b0,
    tdo: 1'b0,
    tdo_oe: 1'b0
  };

  tid_dev_st_t q, d;
  logic [3:0] pins;
  logic rise;
  logic fall;
  logic id_sel;

  tid_sync #(
    .W(4)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({tap.trst_n, tap.tdi, tap.tms, tap.tck}),
    .q(pins)
  );

  function automatic tid_tap_t tid_next(input tid_tap_t s, input logic m);
    case (s)
      TID_TLR: tid_next = m ? TID_TLR : TID_RTI;
      TID_RTI: tid_next = m ? TID_SEL_DR : TID_RTI;
      TID_SEL_DR: tid_next = m ? TID_SEL_IR : TID_CAP_DR_S;
      TID_CAP_DR_S: tid_next = m ? TID_EX1_DR : TID_SH_DR;
      TID_SH_DR: tid_next = m ? TID_EX1_DR : TID_SH_DR;
      TID_EX1_DR: tid_next = m ? TID_UPD_DR : TID_PAU_DR;
      TID_PAU_DR: tid_next = m ? TID_EX2_DR : TID_PAU_DR;
      TID_EX2_DR: tid_next = m ? TID_UPD_DR : TID_SH_DR;
      TID_UPD_DR: tid_next = m ? TID_SEL_DR : TID_RTI;
      TID_SEL_IR: tid_next = m ? TID_TLR : TID_CAP_IR_S;
      TID_CAP_IR_S: tid_next = m ? TID_EX1_IR : TID_SH_IR;
      TID_SH_IR: tid_next = m ? TID_EX1_IR : TID_SH_IR;
      TID_EX1_IR: tid_next = m ? TID_UPD_IR : TID_PAU_IR;
      TID_PAU_IR: tid_next = m ? TID_EX2_IR : TID_PAU_IR;
      TID_EX2_IR: tid_next = m ? TID_UPD_IR : TID_SH_IR;
      TID_UPD_IR: tid_next = m ? TID_SEL_DR : TID_RTI;
      default: tid_next = TID_TLR;
    endcase
  endfunction

  // Fixed fields are parameters; only the version follows the die
  function automatic logic [TID_ID_W-1:0] tid_id_word(input logic [TID_VER_W-1:0] ver);
    logic [TID_ID_W-1:0] w;
    w = '0;
    w[0] = 1'b1;
    w[TID_MAKER_LSB +: TID_MAKER_W] = MAKER;
    w[TID_PART_LSB +: TID_PART_W] = PART;
    w[TID_VER_LSB +: TID_VER_W] = ver;
    tid_id_word = w;
  endfunction

  always_comb begin
    d = q;
    rise = pins[TID_PIN_TCK] & ~q.tck_prev & pins[TID_PIN_TRST];
    fall = ~pins[TID_PIN_TCK] & q.tck_prev;
    // Every code except IDCODE falls back to the one-bit bypass path
    id_sel = (q.ir == TID_IR_IDCODE);
    d.tck_prev = pins[TID_PIN_TCK];
    if (!pins[TID_PIN_TRST]) begin
      d.st = TID_TLR;
    end else if (rise) begin
      d.st = tid_next(q.st, pins[TID_PIN_TMS]);
    end
    if (rise) begin
      case (q.st)
        TID_CAP_IR_S: begin
          d.ir_sh = TID_IR_CAPTURE;
        end
        TID_SH_IR: begin
          d.ir_sh = {pins[TID_PIN_TDI], q.ir_sh[TID_IR_W-1:1]};
        end
        TID_UPD_IR: begin
          d.ir = q.ir_sh;
        end
        TID_CAP_DR_S: begin
          if (id_sel) begin
            d.id_sh = tid_id_word(version);
          end else begin
            d.byp = 1'b0;
          end
        end
        TID_SH_DR: begin
          if (id_sel) begin
            d.id_sh = {pins[TID_PIN_TDI], q.id_sh[TID_ID_W-1:1]};
          end else begin
            d.byp = pins[TID_PIN_TDI];
          end
        end
        default: begin
        end
      endcase
    end
    // Reset by TRST or by five TMS-high clocks both land here
    if (d.st == TID_TLR) begin
      d.ir = TID_IR_IDCODE;
    end
    // TDO changes on the falling test clock so the tester samples a stable bit
    if (fall) begin
      case (q.st)
        TID_SH_IR: begin
          d.tdo = q.ir_sh[0];
          d.tdo_oe = 1'b1;
        end
        TID_SH_DR: begin
          d.tdo = id_sel ? q.id_sh[0] : q.byp;
          d.tdo_oe = 1'b1;
        end
        default: begin
          d.tdo_oe = 1'b0;
        end
      endcase
    end
    if (!pins[TID_PIN_TRST]) begin
      d.tdo_oe = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= TID_DEV_RST;
    end else begin
      q <= d;
    end
  end

  assign tap.tdo = q.tdo;
  assign tap.tdo_oe = q.tdo_oe;
  assign cur_instr = q.ir;
  assign tap_state = q.st;
endmodule

/* File: core/tid_tester.sv */
// Tester end of the test port: AXI4-Lite register slave driving canned TAP walks.
// Assumes the device starts each IR or DR scan from Run-Test/Idle.
`timescale 1ns/1ps
module tid_tester #(
  parameter int unsigned TCK_HALF = tid_pkg::TID_TCK_HALF_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  tid_if.tst tap
);
  import tid_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] data;
    logic [31:0] result;
    logic idp;
    logic refused;
    logic park;
    tid_op_t op;
    tid_eng_t eng;
    logic [63:0] tms_v;
    logic [63:0] tdi_v;
    logic [6:0] idx;
    logic [6:0] len;
    logic [6:0] cap;
    logic [7:0] div;
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } tid_tst_st_t;

  tid_tst_st_t q, d;
  logic tdo_s;
  logic [5:0] ir_code;

  tid_sync #(
    .W(1)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(tap.tdo_line),
    .q(tdo_s)
  );

  function automatic logic [31:0] tid_merge(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    tid_merge = r;
  endfunction

  function automatic logic tid_reserved(input logic [5:0] c);
    tid_reserved = ((c >= TID_RSV1_LO) && (c <= TID_RSV1_HI)) ||
                   ((c >= TID_RSV2_LO) && (c <= TID_RSV2_HI));
  endfunction

  always_comb begin
    d = q;
    ir_code = q.w_data[TID_CMD_IR_LSB +: 6];
    // Scan engine; TCK only toggles while a walk runs
    case (q.eng)
      TID_ENG_LOW: begin
        d.div = q.div + 8'h01;
        if (q.div == 8'(TCK_HALF - 1)) begin
          d.div = '0;
          d.tck = 1'b1;
          d.eng = TID_ENG_HIGH;
          if ((q.idx >= q.cap) && (q.idx < q.cap + TID_CAP_SPAN)) begin
            d.result = {tdo_s, q.result[31:1]};
          end
        end
      end
      TID_ENG_HIGH: begin
        d.div = q.div + 8'h01;
        if (q.div == 8'(TCK_HALF - 1)) begin
          d.div = '0;
          d.tck = 1'b0;
          d.idx = q.idx + 7'h01;
          d.tms = q.tms_v[d.idx[5:0]];
          d.tdi = q.tdi_v[d.idx[5:0]];
          d.eng = TID_ENG_LOW;
          if (q.idx == q.len - 7'h01) begin
            d.eng = TID_ENG_IDLE;
            d.tms = 1'b0;
            d.tdi = 1'b0;
            if (q.op == TID_OP_READ_ID) begin
              d.idp = q.result[0];
            end
          end
        end
      end
      default: begin
        d.tck = 1'b0;
      end
    endcase
    // AXI4-Lite write side
    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = 2'b00;
      if (q.aw_addr == TID_REG_CMD) begin
        // A command while busy is dropped; software polls busy first
        if (q.eng == TID_ENG_IDLE && q.w_strb != 4'h0) begin
          d.op = tid_op_t'(q.w_data[1:0]);
          d.refused = 1'b0;
          d.tdi_v = '0;
          d.cap = TID_CAP_NONE;
          case (tid_op_t'(q.w_data[1:0]))
            TID_OP_RESET: begin
              d.tms_v = TID_TMS_RESET;
              d.len = TID_LEN_RESET;
            end
            TID_OP_READ_ID: begin
              d.tms_v = TID_TMS_ID;
              d.len = TID_LEN_ID;
              d.cap = TID_CAP_ID;
            end
            TID_OP_SCAN_IR: begin
              d.tms_v = TID_TMS_IR;
              d.len = TID_LEN_IR;
              d.cap = TID_CAP_IR;
              d.tdi_v = {54'h0, ir_code, 4'h0};
            end
            default: begin
              d.tms_v = TID_TMS_DR;
              d.len = TID_LEN_DR;
              d.cap = TID_CAP_DR;
              d.tdi_v = {29'h0, q.data, 3'h0};
            end
          endcase
          if (tid_op_t'(q.w_data[1:0]) == TID_OP_SCAN_IR && tid_reserved(ir_code)) begin
            d.refused = 1'b1;
          end else begin
            d.eng = TID_ENG_LOW;
            d.idx = '0;
            d.div = '0;
            d.tms = d.tms_v[0];
            d.tdi = d.tdi_v[0];
          end
        end
      end else if (q.aw_addr == TID_REG_DATA) begin
        d.data = tid_merge(q.data, q.w_data, q.w_strb);
      end else if (q.aw_addr == TID_REG_PARK) begin
        if (q.w_strb[0]) begin
          d.park = q.w_data[0];
        end
      end else if (q.aw_addr != TID_REG_RESULT && q.aw_addr != TID_REG_STATUS) begin
        d.bresp = 2'b10;
      end
    end
    // AXI4-Lite read side
    if (s_axi_rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = 2'b00;
      d.rdata = '0;
      if (s_axi_araddr == TID_REG_CMD) begin
        d.rdata = '0;
      end else if (s_axi_araddr == TID_REG_DATA) begin
        d.rdata = q.data;
      end else if (s_axi_araddr == TID_REG_RESULT) begin
        d.rdata = q.result;
      end else if (s_axi_araddr == TID_REG_STATUS) begin
        d.rdata[TID_ST_BUSY] = (q.eng != TID_ENG_IDLE);
        d.rdata[TID_ST_IDP] = q.idp;
        d.rdata[TID_ST_REFUSED] = q.refused;
      end else if (s_axi_araddr == TID_REG_PARK) begin
        d.rdata[0] = q.park;
      end else begin
        d.rresp = 2'b10;
      end
    end
    d.awready = !d.aw_got && !d.bvalid;
    d.wready = !d.w_got && !d.bvalid;
    d.arready = !d.rvalid;
    d.trst_n = !d.park;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.data <= TID_DATA_RST;
      q.park <= TID_PARK_RST;
      q.op <= TID_OP_RESET;
      q.eng <= TID_ENG_IDLE;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.trst_n <= !TID_PARK_RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign tap.tck = q.tck;
  assign tap.tms = q.tms;
  assign tap.tdi = q.tdi;
  assign tap.trst_n = q.trst_n;
endmodule

/* File: tb/tid_checker.sv */
// Assertions on the test port wires between tester and device.
// Assumes the bench instantiates it beside the interface that joins the two ends.
`timescale 1ns/1ps
module tid_checker #(
  parameter int unsigned TCK_HALF = tid_pkg::TID_TCK_HALF_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic tdo_line,
  input wire logic [tid_pkg::TID_IR_W-1:0] cur_instr,
  input wire tid_pkg::tid_tap_t tap_state
);
  import tid_pkg::*;
  typedef struct packed {
    logic tck;
    logic [3:0] ones;
    logic [7:0] hi;
  } tid_chk_t;
  tid_chk_t chk_q;
  tid_chk_t chk_d;
  always_comb begin
    chk_d = chk_q;
    chk_d.tck = tck;
    chk_d.hi = tck ? chk_q.hi + 8'h01 : 8'h00;
    if (tck && !chk_q.tck) begin
      // Saturates so a long run of tms high never wraps back below five
      chk_d.ones = !tms ? 4'h0 : (chk_q.ones == 4'hf) ? 4'hf : chk_q.ones + 4'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chk_q <= '0;
    end else begin
      chk_q <= chk_d;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Device sees the pins through synchronisers, hence the slack
  AST_TMS_RESET: assert property (chk_q.ones >= 4'h5 |-> ##[0:8] tap_state == TID_TLR)
    else $error("no reset after five tms high clocks");
  AST_TRST_TLR: assert property ((!trst_n) [*5] |-> tap_state == TID_TLR && !tdo_oe)
    else $error("test reset ignored");
  AST_TLR_IDCODE: assert property ((tap_state == TID_TLR) [*2] |-> cur_instr == TID_IR_IDCODE)
    else $error("reset state without identification instruction");
  AST_IR_UPDATE: assert property ($changed(cur_instr) |->
    tap_state inside {TID_UPD_IR, TID_TLR} || $past(tap_state) inside {TID_UPD_IR, TID_TLR})
    else $error("instruction changed outside update");
  AST_OE_SHIFT: assert property ($rose(tdo_oe) |-> tap_state inside {TID_SH_DR, TID_SH_IR})
    else $error("tdo driven outside shift");
  AST_TDO_STABLE: assert property ($rose(tck) |-> $stable(tdo) && $stable(tdo_line))
    else $error("tdo moved at tck rise");
  AST_PIN_SETUP: assert property ($rose(tck) |-> $stable(tms) && $stable(tdi))
    else $error("tms or tdi moved at tck rise");
  AST_TCK_HIGH: assert property ($fell(tck) |-> chk_q.hi == TCK_HALF)
    else $error("tck high time wrong");
  cover property (tap_state == TID_SH_DR && cur_instr == TID_IR_IDCODE);
  cover property (tap_state == TID_SH_DR && cur_instr == TID_IR_BYPASS);
  cover property (tap_state == TID_SH_IR);
endmodule

/* File: tb/tb.sv */
// Self-checking bench: tester and device joined by the test port interface.
// Assumes the tester register map and walks of the shared package.
`timescale 1ns/1ps
module tb;
  import tid_pkg::*;
  localparam int unsigned HALF = 6;
  localparam logic [10:0] MAKER_V = 11'h2a5;  // Arbitrary value
  localparam logic [15:0] PART_V = 16'hc3e1;  // Arbitrary value
  localparam logic [31:0] ID_A = {4'ha, PART_V, MAKER_V, 1'b1};
  localparam logic [31:0] ID_5 = {4'h5, PART_V, MAKER_V, 1'b1};
  // IR walks sample eight bits: six captured pattern bits, then two ones from the released line
  localparam logic [31:0] PAT = 32'hed00_0000;
  localparam logic [31:0] IRM = 32'hff00_0000;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  typedef struct packed {
    logic [3:0] ver;
    logic [31:0] cmd;
    logic [31:0] data;
    logic [31:0] mask;
    logic [31:0] exp;
    logic [5:0] ir;
  } tid_row_t;
  // Bypass rows expect the data one bit late behind the captured 0
  localparam tid_row_t ROWS [8] = '{
    '{4'ha, 32'h1, 32'h0, ALL, ID_A, 6'h02},
    '{4'ha, 32'h3f02, 32'h0, IRM, PAT, 6'h3f},
    '{4'ha, 32'h3, 32'ha5a5_0f0f, ALL, 32'h4b4a_1e1e, 6'h3f},
    '{4'ha, 32'h3d02, 32'h0, IRM, PAT, 6'h3d},
    '{4'ha, 32'h3, 32'h8000_0001, ALL, 32'h2, 6'h3d},
    '{4'ha, 32'h0202, 32'h0, IRM, PAT, 6'h02},
    '{4'ha, 32'h3, ALL, ALL, ID_A, 6'h02},
    '{4'h5, 32'h1, 32'h0, ALL, ID_5, 6'h02}
  };
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [3:0] ver = 4'ha;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [5:0] cur_instr;
  tid_tap_t tap_state;
  logic [5:0] rsv [4] = '{6'h04, 6'h2c, 6'h2e, 6'h3c};
  int error_cnt = 0;
  int cmp_count = 0;
  always #2.5 aclk = ~aclk;
  tid_if tif ();
  tid_device #(.MAKER(MAKER_V), .PART(PART_V)) tid_device_i (.aclk(aclk), .aresetn(aresetn),
    .tap(tif), .version(ver), .cur_instr(cur_instr), .tap_state(tap_state));
  tid_tester #(.TCK_HALF(HALF)) tid_tester_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tap(tif));
  tid_checker #(.TCK_HALF(HALF)) tid_checker_i (.aclk(aclk), .aresetn(aresetn), .tck(tif.tck),
    .tms(tif.tms), .tdi(tif.tdi), .trst_n(tif.trst_n), .tdo(tif.tdo), .tdo_oe(tif.tdo_oe),
    .tdo_line(tif.tdo_line), .cur_instr(cur_instr), .tap_state(tap_state));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    r = bresp;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  // Busy is already up when the write answer to an accepted command arrives, so polling cannot see a stale idle
  task automatic run(input logic [31:0] cmd);
    wr(TID_REG_CMD, cmd, rsp);
    do begin
      rdr(TID_REG_STATUS, rd, rsp);
    end while (rd[TID_ST_BUSY] !== 1'b0);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(cur_instr), 32'(TID_IR_IDCODE));
    chk(32'(tap_state), 32'(TID_TLR));
    chk(32'({tif.tck, tif.trst_n}), 32'h0);
    rdr(TID_REG_DATA, rd, rsp);
    chk(rd, TID_DATA_RST);
    rdr(TID_REG_PARK, rd, rsp);
    chk(rd, 32'(TID_PARK_RST));
    rdr(8'h14, rd, rsp);
    chk({rd[29:0], rsp}, 32'h2);
    wr(8'h14, 32'h1, rsp);
    chk(32'(rsp), 32'h2);
    wr(TID_REG_PARK, 32'h0, rsp);
    run(32'h0);
    foreach (ROWS[i]) begin
      ver <= ROWS[i].ver;
      wr(TID_REG_DATA, ROWS[i].data, rsp);
      run(ROWS[i].cmd);
      rdr(TID_REG_RESULT, rd, rsp);
      chk(rd & ROWS[i].mask, ROWS[i].exp);
      chk(32'(cur_instr), 32'(ROWS[i].ir));
    end
    rdr(TID_REG_STATUS, rd, rsp);
    chk(32'(rd[TID_ST_IDP]), 32'h1);
    foreach (rsv[i]) begin
      run({18'h0, rsv[i], 8'h02});
      rdr(TID_REG_STATUS, rd, rsp);
      chk(32'({rd[TID_ST_REFUSED], cur_instr}), 32'h42);
    end
    // A command written while busy is dropped, so the instruction stays put
    wr(TID_REG_CMD, 32'h1, rsp);
    run(32'h3f02);
    chk(32'(cur_instr), 32'(TID_IR_IDCODE));
    run(32'h3f02);
    run(32'h0);
    chk(32'(cur_instr), 32'(TID_IR_IDCODE));
    run(32'h3f02);
    wr(TID_REG_PARK, 32'h1, rsp);
    repeat (8) @(posedge aclk);
    chk(32'({tap_state, cur_instr}), 32'({TID_TLR, TID_IR_IDCODE}));
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    end_of_test();
  end
endmodule
